// ===== verilog/fhl_regs.vh
// Register map, field widths and timing constants of the fault history log
`ifndef FHL_REGS_VH
`define FHL_REGS_VH

// Word offsets on the APB bus
`define FHL_OFS_STATUS      12'h000
`define FHL_OFS_MASK        12'h004
`define FHL_OFS_CTRL        12'h008
`define FHL_OFS_NOW_HOURS   12'h00c
`define FHL_OFS_NOW_MINUTES 12'h010
`define FHL_OFS_FILL        12'h014
`define FHL_BASE_CODE       12'h040
`define FHL_BASE_HOURS      12'h080
`define FHL_BASE_MINUTES    12'h0c0
`define FHL_BASE_SPAN       12'h040

// Status and mask bits
`define FHL_ST_LOGGED       0
`define FHL_ST_REPEAT       1
`define FHL_ST_BADCODE      2
`define FHL_ST_HRSAT        3
`define FHL_ST_W            4

// Control bits
`define FHL_CTRL_LOG_EN     0
`define FHL_CTRL_TMR_CLR    1
`define FHL_CTRL_RESET      2'h1

// Field widths and limits
`define FHL_CODE_W          7
`define FHL_CODE_MAX        7'h7a
`define FHL_HOURS_W         15
`define FHL_HOURS_MAX       15'h7fff
`define FHL_TENTHS_W        10
`define FHL_TENTHS_WRAP     10'h258
`define FHL_SLOTS           10

// Timing: one tenth of a minute, pclk period 5 ns
`define FHL_TENTH_MIN_MS    6000
`define FHL_PCLK_NS         5
`define FHL_NS_PER_MS       1000000

`endif

// ===== verilog/fhl_sync3.v
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/10ps
module fhl_sync3 (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Level in and filtered level out
  input  wire async_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts once the last two stages agree
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // fhl_sync3

// ===== verilog/fhl_elapsed_timer.v
// Elapsed powered-up time counter: tenths of a minute and saturating hours
`timescale 1ns/10ps
`include "fhl_regs.vh"
module fhl_elapsed_timer #(
  parameter [31:0] TICK_CYCLES = 32'd1200000000
) (
  // Clock and reset
  input  wire                       pclk,
  input  wire                       presetn,
  // Control
  input  wire                       clear,
  // Elapsed time
  output reg  [`FHL_HOURS_W-1:0]    hours_q,
  output reg  [`FHL_TENTHS_W-1:0]   tenths_q,
  output wire                       hours_sat
);
  reg  [31:0] div_q;
  wire        tick = (div_q == TICK_CYCLES - 32'd1);

  assign hours_sat = (hours_q == `FHL_HOURS_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q    <= 32'h0;
      hours_q  <= {`FHL_HOURS_W{1'b0}};
      tenths_q <= {`FHL_TENTHS_W{1'b0}};
    end else if (clear) begin
      div_q    <= 32'h0;
      hours_q  <= {`FHL_HOURS_W{1'b0}};
      tenths_q <= {`FHL_TENTHS_W{1'b0}};
    end else begin
      div_q <= tick ? 32'h0 : div_q + 32'd1;
      if (tick) begin
        if (tenths_q == `FHL_TENTHS_WRAP - 10'h1) begin
          tenths_q <= {`FHL_TENTHS_W{1'b0}};
          // Hour count stops at its maximum
          if (!hours_sat) begin // RQ7
            hours_q <= hours_q + 15'h1;
          end
        end else begin
          tenths_q <= tenths_q + 10'h1;
        end
      end
    end
  end
endmodule // fhl_elapsed_timer

// ===== verilog/fhl_fault_history_log.v
// Fault history log: ten-slot fault queue with time stamps, APB slave
//
// Function
// RQ1: Each slot holds one past fault code in the range 0 to 122, read-only, slot index = recency.
// RQ2: Faults enter in order of occurrence and slot one always holds the newest.
// RQ3: On a logged fault each slot up to the tenth takes its newer neighbour, the oldest is lost.
// RQ4: A fault equal to the newest recorded one is not logged a second time.
// RQ5: Each logged fault captures the elapsed hour count, 0 to 32767, into its hour stamp.
// RQ6: Each logged fault captures the elapsed minutes, 0.0 to 59.9 in 0.1 steps, into its stamp. The counter wraps after 59.9 (tenths 0 to 599).
// RQ7: The elapsed hour counter saturates and stops at 32767.
// RQ8: Hour and minute stamps shift with their fault code and stay in the same slot.
`timescale 1ns/10ps
`include "fhl_regs.vh"
module fhl_fault_history_log #(
  parameter integer SLOTS       = `FHL_SLOTS,
  parameter [31:0]  TICK_CYCLES = `FHL_TENTH_MIN_MS * (`FHL_NS_PER_MS / `FHL_PCLK_NS)
) (
  // Clock and reset
  input  wire                      pclk,
  input  wire                      presetn,
  // APB slave
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [11:0]               paddr,
  input  wire [31:0]               pwdata,
  input  wire [3:0]                pstrb,
  output wire                      pready,
  output reg  [31:0]               prdata,
  output reg                       pslverr,
  // Fault event from drive logic on pclk
  input  wire                      fault_valid,
  input  wire [`FHL_CODE_W-1:0]    fault_code,
  // Elapsed timer clear from an external pin
  input  wire                      timer_clear_pin,
  // Newest slot and interrupt
  output reg  [`FHL_CODE_W-1:0]    newest_fault_slot,
  output reg                       irq
);
  // History storage, slot 0 is the newest
  wire [`FHL_CODE_W-1:0]   code_q   [0:SLOTS-1];
  wire [`FHL_HOURS_W-1:0]  hours_q  [0:SLOTS-1];
  wire [`FHL_TENTHS_W-1:0] tenths_q [0:SLOTS-1];
  reg  [4:0]               fill_q;

  reg  [`FHL_ST_W-1:0]     status_q;
  reg  [`FHL_ST_W-1:0]     status_d;
  reg  [`FHL_ST_W-1:0]     mask_q;
  reg  [1:0]               ctrl_q;
  reg                      hrsat_q;

  wire [`FHL_HOURS_W-1:0]  elapsed_hours_counter;
  wire [`FHL_TENTHS_W-1:0] elapsed_minutes_counter;
  wire                     hours_sat;
  wire                     pin_clear;

  // Timer clear from pin or software
  fhl_sync3 u_clr_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (timer_clear_pin),
    .level_q  (pin_clear)
  );

  fhl_elapsed_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (pin_clear | ctrl_q[`FHL_CTRL_TMR_CLR]),
    .hours_q   (elapsed_hours_counter),
    .tenths_q  (elapsed_minutes_counter),
    .hours_sat (hours_sat)
  );

  // Fault qualification
  wire code_ok  = (fault_code <= `FHL_CODE_MAX);                             // RQ1
  wire repeated = (fill_q != 5'h0) && (fault_code == code_q[0]);               // RQ4
  wire log_en   = ctrl_q[`FHL_CTRL_LOG_EN];
  wire take     = fault_valid && log_en && code_ok && !repeated;               // RQ4

  // Shift chain: slot 0 loads the new fault, slot i loads slot i-1
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi = gi + 1) begin : g_slot
      reg  [`FHL_CODE_W-1:0]   slot_code_q;
      reg  [`FHL_HOURS_W-1:0]  slot_hours_q;
      reg  [`FHL_TENTHS_W-1:0] slot_tenths_q;
      wire [`FHL_CODE_W-1:0]   code_in;
      wire [`FHL_HOURS_W-1:0]  hours_in;
      wire [`FHL_TENTHS_W-1:0] tenths_in;
      if (gi == 0) begin : g_head
        assign code_in   = fault_code;                                         // RQ2
        assign hours_in  = elapsed_hours_counter;                              // RQ5
        assign tenths_in = elapsed_minutes_counter;                            // RQ6
      end else begin : g_tail
        assign code_in   = code_q[gi-1];                                       // RQ3
        assign hours_in  = hours_q[gi-1];                                      // RQ8
        assign tenths_in = tenths_q[gi-1];                                     // RQ8
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_code_q   <= {`FHL_CODE_W{1'b0}};
          slot_hours_q  <= {`FHL_HOURS_W{1'b0}};
          slot_tenths_q <= {`FHL_TENTHS_W{1'b0}};
        end else if (take) begin
          slot_code_q   <= code_in;
          slot_hours_q  <= hours_in;
          slot_tenths_q <= tenths_in;
        end
      end
      assign code_q[gi]   = slot_code_q;
      assign hours_q[gi]  = slot_hours_q;
      assign tenths_q[gi] = slot_tenths_q;
    end
  endgenerate

  // Number of valid entries
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q            <= 5'h0;
      newest_fault_slot <= {`FHL_CODE_W{1'b0}};
    end else if (take) begin
      newest_fault_slot <= fault_code;                                         // RQ2
      if (fill_q != SLOTS[4:0]) begin
        fill_q <= fill_q + 5'h1;
      end
    end
  end

  // APB decode
  wire        setup    = psel && !penable;
  wire        access   = psel && penable;
  wire        wr_acc   = access && pwrite;
  wire [11:0] word_a   = {paddr[11:2], 2'b00};
  wire [11:0] slot_off = word_a & (`FHL_BASE_SPAN - 12'h4);
  wire [3:0]  slot_idx = slot_off[5:2];
  wire        slot_hit = (slot_idx < SLOTS[3:0]);
  wire [11:0] region   = word_a & ~(`FHL_BASE_SPAN - 12'h4);

  assign pready = 1'b1;

  reg [31:0] rd_val;
  reg        rd_hit;
  always @* begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (word_a)
      `FHL_OFS_STATUS:      rd_val = {{(32-`FHL_ST_W){1'b0}}, status_q};
      `FHL_OFS_MASK:        rd_val = {{(32-`FHL_ST_W){1'b0}}, mask_q};
      `FHL_OFS_CTRL:        rd_val = {30'h0, ctrl_q};
      `FHL_OFS_NOW_HOURS:   rd_val = {17'h0, elapsed_hours_counter};
      `FHL_OFS_NOW_MINUTES: rd_val = {22'h0, elapsed_minutes_counter};
      `FHL_OFS_FILL:        rd_val = {27'h0, fill_q};
      default: begin
        rd_hit = slot_hit;
        if (!slot_hit) begin
          rd_hit = 1'b0;
        end else if (region == `FHL_BASE_CODE) begin
          rd_val = {25'h0, code_q[slot_idx]};                                  // RQ1
        end else if (region == `FHL_BASE_HOURS) begin
          rd_val = {17'h0, hours_q[slot_idx]};                                 // RQ5
        end else if (region == `FHL_BASE_MINUTES) begin
          rd_val = {22'h0, tenths_q[slot_idx]};                                // RQ6
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Only mask and control accept writes
  wire wr_ok = (word_a == `FHL_OFS_MASK) || (word_a == `FHL_OFS_CTRL);

  // Read data captured in the setup cycle, presented in the access cycle
  reg [`FHL_ST_W-1:0] st_snap_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0;
      pslverr   <= 1'b0;
      st_snap_q <= {`FHL_ST_W{1'b0}};
    end else if (setup) begin
      prdata    <= pwrite ? 32'h0 : (rd_hit ? rd_val : 32'h0);
      pslverr   <= pwrite ? !wr_ok : !rd_hit;
      st_snap_q <= (!pwrite && word_a == `FHL_OFS_STATUS) ?
                   status_q : {`FHL_ST_W{1'b0}};
    end else if (access) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  // Mask and control writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= {`FHL_ST_W{1'b0}};
      ctrl_q <= `FHL_CTRL_RESET;
    end else begin
      // Timer clear is a self-clearing strobe
      ctrl_q[`FHL_CTRL_TMR_CLR] <= 1'b0;
      if (wr_acc && pstrb[0]) begin
        if (word_a == `FHL_OFS_MASK) begin
          mask_q <= pwdata[`FHL_ST_W-1:0];
        end
        if (word_a == `FHL_OFS_CTRL) begin
          ctrl_q <= pwdata[1:0];
        end
      end
    end
  end

  // Sticky status, read clears only the bits that were read, set wins
  wire sat_rise = hours_sat && !hrsat_q;
  always @* begin
    status_d = status_q;
    if (access && !pwrite && word_a == `FHL_OFS_STATUS) begin
      status_d = status_q & ~st_snap_q;
    end
    if (take) begin
      status_d[`FHL_ST_LOGGED] = 1'b1;
    end
    if (fault_valid && log_en && code_ok && repeated) begin
      status_d[`FHL_ST_REPEAT] = 1'b1;
    end
    if (fault_valid && log_en && !code_ok) begin
      status_d[`FHL_ST_BADCODE] = 1'b1;
    end
    if (sat_rise) begin
      status_d[`FHL_ST_HRSAT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= {`FHL_ST_W{1'b0}};
      hrsat_q  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      hrsat_q  <= hours_sat;
      irq      <= |(status_d & mask_q);
    end
  end
endmodule // fhl_fault_history_log

// ===== verification/fhl_log_sva.sv
// Port checker for the fault history log
`timescale 1ns/10ps
`include "fhl_regs.vh"
module fhl_log_sva (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // Faults
  input logic        fault_valid,
  input logic [6:0]  fault_code,
  input logic [6:0]  newest_fault_slot
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence slot_wr_s; setup_s ##0 (pwrite && paddr >= 12'h040 && paddr < 12'h100); endsequence
  sequence gap_rd_s;
    setup_s ##0 (!pwrite && paddr >= 12'h040 && paddr < 12'h100 && paddr[5:2] >= 4'ha);
  endsequence
  code_range_a: assert property (newest_fault_slot <= `FHL_CODE_MAX)
    else $error("newest code out of range");
  bad_code_a: assert property (fault_valid && fault_code > 7'h7a |=> $stable(newest_fault_slot))
    else $error("out of range code logged");
  newest_src_a: assert property (!$stable(newest_fault_slot) |->
    $past(fault_valid) && newest_fault_slot == $past(fault_code))
    else $error("newest slot changed without matching fault");
  slot_ro_a: assert property (slot_wr_s |=> pslverr)
    else $error("slot write not refused");
  slot_gap_a: assert property (gap_rd_s |=> pslverr && prdata == 32'h0)
    else $error("slot beyond tenth answered");
  rdata_idle_a: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("read data outside access");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag outside access");
  ready_tied_a: assert property (pready)
    else $error("ready low");
endmodule // fhl_log_sva

bind fhl_fault_history_log fhl_log_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .prdata, .pslverr, .fault_valid, .fault_code, .newest_fault_slot);

// ===== verification/tb.sv
// Self-checking bench for the fault history log
`timescale 1ns/10ps
`include "fhl_regs.vh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        fault_valid = 1'b0;
  logic        timer_clear_pin = 1'b0;
  logic [6:0]  fault_code = 7'h00;
  logic [31:0] prdata, rd, t0, s0;
  logic        pready, pslverr, irq, er;
  logic [6:0]  newest_fault_slot;
  logic [6:0]  hist [10];
  int          n_errors = 0;
  int          compares = 0;
  int          fill = 0;
  // Rows: fault code in, newest slot expected
  logic [6:0]  row_code [14] = '{7'h05, 7'h05, 7'h09, 7'h7b, 7'h00, 7'h7a, 7'h07,
                                 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h08, 7'h0a};
  logic [6:0]  row_exp [14]  = '{7'h05, 7'h05, 7'h09, 7'h09, 7'h00, 7'h7a, 7'h07,
                                 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h08, 7'h0a};

  fhl_fault_history_log #(.TICK_CYCLES(32'd4)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .pready, .prdata, .pslverr, .fault_valid, .fault_code, .timer_clear_pin,
    .newest_fault_slot, .irq);

  always #2.5 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One fault pulse, reference history kept alongside
  task fault(input logic [6:0] c);
    @(posedge pclk);
    fault_valid <= 1'b1;
    fault_code <= c;
    @(posedge pclk);
    fault_valid <= 1'b0;
    #1;
    if (c <= 7'h7a && !(fill > 0 && c == hist[0])) begin
      for (int i = 9; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = c;
      if (fill < 10) fill++;
    end
  endtask

  task end_of_test;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end

  initial begin
    foreach (hist[i]) hist[i] = 7'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(newest_fault_slot, 32'h0);
    chk_flag(irq, 1'b0);
    apb(1'b0, `FHL_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    for (int r = 0; r < 14; r++) begin
      fault(row_code[r]);
      chk(newest_fault_slot, row_exp[r]);
    end
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'(`FHL_BASE_CODE + 4 * i), 32'h0);
      chk(rd, hist[i]);
    end
    apb(1'b0, `FHL_OFS_FILL, 32'h0);
    chk(rd, 32'ha);
    apb(1'b0, 12'h068, 32'h0);
    chk_flag(er, 1'b1);
    apb(1'b1, 12'h058, 32'h11);
    chk_flag(er, 1'b1);
    apb(1'b0, 12'h058, 32'h0);
    chk(rd, hist[6]);
    // Past one hour of elapsed time
    repeat (2500) @(posedge pclk);
    apb(1'b0, `FHL_OFS_NOW_MINUTES, 32'h0);
    t0 = rd;
    fault(7'h32);
    apb(1'b0, `FHL_BASE_MINUTES, 32'h0);
    s0 = rd;
    chk_flag(s0 >= t0 && s0 - t0 <= 32'h3, 1'b1);
    apb(1'b0, `FHL_BASE_HOURS, 32'h0);
    chk(rd, 32'h1);
    fault(7'h33);
    apb(1'b0, 12'(`FHL_BASE_MINUTES + 4), 32'h0);
    chk(rd, s0);
    apb(1'b0, 12'(`FHL_BASE_HOURS + 4), 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `FHL_OFS_STATUS, 32'h0);
    apb(1'b1, `FHL_OFS_MASK, 32'h2);
    fault(7'h33);
    chk(newest_fault_slot, 32'h33);
    @(posedge pclk);
    #1;
    chk_flag(irq, 1'b1);
    apb(1'b0, `FHL_OFS_STATUS, 32'h0);
    chk(rd, 32'h2);
    @(posedge pclk);
    #1;
    chk_flag(irq, 1'b0);
    fault(7'h34);
    repeat (2) @(posedge pclk);
    #1;
    chk_flag(irq, 1'b0);
    // Logging disabled: fault ignored
    apb(1'b1, `FHL_OFS_CTRL, 32'h0);
    fault(7'h35);
    chk(newest_fault_slot, 32'h34);
    // Software timer clear strobe, self-clearing
    apb(1'b1, `FHL_OFS_CTRL, 32'h3);
    apb(1'b0, `FHL_OFS_NOW_HOURS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `FHL_OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    // Pin clear holds the timer at zero
    repeat (40) @(posedge pclk);
    timer_clear_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `FHL_OFS_NOW_MINUTES, 32'h0);
    chk(rd, 32'h0);
    timer_clear_pin <= 1'b0;
    // Reset in mid-run empties the log
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk(newest_fault_slot, 32'h0);
    chk_flag(irq, 1'b0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FHL_OFS_FILL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `FHL_BASE_CODE, 32'h0);
    chk(rd, 32'h0);
    end_of_test;
  end
endmodule // tb
